// ==== iolfs_top.sv ====
/*
 * per-line function select for the configurable i/o lines: holds one
 * function code per line, decodes it into pad direction, output level,
 * analog select and alternate select, and builds the digital sample word.
 * assumes pad inputs are asynchronous and the host write is synchronous.
 */
// Function
// - each configurable line has its own code; 0 is unmonitored digital input and 3 monitored digital input.
// - code 2 selects single-ended analog input and is taken only on analog-capable lines.
// - code 4 makes the line a digital output starting low.
// - code 5 makes the line a digital output starting high.
// - code 1 selects the line's own alternate function.
// - codes 6 to 9 select further alternate functions only on lines that have them.
// - the sleep request and sleep status lines have no function setting and keep fixed roles.
// - each digital input line has a pull-up enable independent of its function code.
// - lines 0 to 3 allow analog, digital and alternate (code 1) modes, lines 4 to 7 and 10 to 12 digital and alternate only.
// - a line not set as digital input reads zero in the digital sample word.
`timescale 1ns/1ps
`default_nettype none
module iolfs_top
    import iolfs_pkg::*;
#(
    parameter int unsigned NUM_LINES = IOLFS_NUM_LINES
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire iolfs_cfg_wr_s cfg_wr_in,
    input wire logic [12:0] pullup_enable_setting_in,
    input wire logic [12:0] pad_level_in,
    input wire logic sleep_active_in,
    output logic cfg_reject_out,
    output logic [12:0] pad_oe_out,
    output logic [12:0] pad_level_out,
    output logic [12:0] pad_pullup_out,
    output logic [12:0] analog_sel_out,
    output logic [12:0] alt_sel_out,
    output logic [12:0] monitored_out,
    output logic [12:0] dig_sample_out,
    output logic [51:0] fn_code_out
);
    // ***********************************************************
    // configuration store
    // ***********************************************************
    logic [3:0] fn_code [13];
    logic [3:0] next_fn_code [13];
    logic reject;
    logic next_reject;
    logic accept;

    iolfs_code_check u_check (
        .line_in(cfg_wr_in.line),
        .code_in(cfg_wr_in.code),
        .accept_out(accept)
    );

    always_comb begin
        next_reject = 1'b0;
        for (int i = 0; i < 13; i++) begin
            next_fn_code[i] = fn_code[i];
        end
        if (cfg_wr_in.wr) begin
            if (accept) begin
                next_fn_code[cfg_wr_in.line] = cfg_wr_in.code;
            end else begin
                next_reject = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < 13; i++) begin
                fn_code[i] <= IOLFS_FN_RESET;
            end
            reject <= 1'b0;
        end else begin
            for (int i = 0; i < 13; i++) begin
                fn_code[i] <= next_fn_code[i];
            end
            reject <= next_reject;
        end
    end

    // ***********************************************************
    // pad input synchroniser
    // ***********************************************************
    logic [12:0] pad_meta;
    logic [12:0] pad_sync;
    logic sleep_meta;
    logic sleep_sync;

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            pad_meta <= 13'h0000;
            pad_sync <= 13'h0000;
            sleep_meta <= 1'b0;
            sleep_sync <= 1'b0;
        end else begin
            pad_meta <= pad_level_in;
            pad_sync <= pad_meta;
            sleep_meta <= sleep_active_in;
            sleep_sync <= sleep_meta;
        end
    end

    // ***********************************************************
    // per-line decode
    // ***********************************************************
    logic [12:0] next_oe;
    logic [12:0] next_lvl;
    logic [12:0] next_pu;
    logic [12:0] next_ana;
    logic [12:0] next_alt;
    logic [12:0] next_mon;
    logic [12:0] next_samp;
    logic [12:0] is_din;
    logic [12:0] oe_r;
    logic [12:0] lvl_r;
    logic [12:0] pu_r;
    logic [12:0] ana_r;
    logic [12:0] alt_r;
    logic [12:0] mon_r;
    logic [12:0] samp_r;

    genvar g;
    generate
        for (g = 0; g < 13; g++) begin : g_line
            if (g == IOLFS_SLEEP_REQ_LINE) begin : g_sreq
                // fixed input role, no function store read
                always_comb begin
                    is_din[g] = 1'b1;
                    next_oe[g] = 1'b0;
                    next_lvl[g] = 1'b0;
                    next_ana[g] = 1'b0;
                    next_alt[g] = 1'b0;
                    next_mon[g] = 1'b0;
                end
            end else if (g == IOLFS_SLEEP_STAT_LINE) begin : g_sstat
                always_comb begin
                    is_din[g] = 1'b0;
                    next_oe[g] = 1'b1;
                    next_lvl[g] = sleep_sync;
                    next_ana[g] = 1'b0;
                    next_alt[g] = 1'b0;
                    next_mon[g] = 1'b0;
                end
            end else begin : g_cfg
                always_comb begin
                    is_din[g] = 1'b0;
                    next_oe[g] = 1'b0;
                    next_lvl[g] = 1'b0;
                    next_ana[g] = 1'b0;
                    next_alt[g] = 1'b0;
                    next_mon[g] = 1'b0;
                    case (fn_code[g])
                        IOLFS_FN_DIN_UNMON: begin
                            is_din[g] = 1'b1;
                        end
                        IOLFS_FN_DIN_MON: begin
                            is_din[g] = 1'b1;
                            next_mon[g] = 1'b1;
                        end
                        IOLFS_FN_ANALOG: begin
                            next_ana[g] = 1'b1;
                        end
                        IOLFS_FN_DOUT_LOW: begin
                            next_oe[g] = 1'b1;
                            next_lvl[g] = 1'b0;
                        end
                        IOLFS_FN_DOUT_HIGH: begin
                            next_oe[g] = 1'b1;
                            next_lvl[g] = 1'b1;
                        end
                        default: begin
                            // code 1 and accepted 6..9: pad handed to the alternate function
                            next_alt[g] = 1'b1;
                        end
                    endcase
                end
            end
            always_comb begin
                next_pu[g] = pullup_enable_setting_in[g] & is_din[g];
                next_samp[g] = is_din[g] & pad_sync[g];
            end
            assign fn_code_out[g*4 +: 4] = fn_code[g];
        end
    endgenerate

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            oe_r <= 13'h0000;
            lvl_r <= 13'h0000;
            pu_r <= IOLFS_PULLUP_RESET;
            ana_r <= 13'h0000;
            alt_r <= 13'h0000;
            mon_r <= 13'h0000;
            samp_r <= 13'h0000;
        end else begin
            oe_r <= next_oe;
            lvl_r <= next_lvl;
            pu_r <= next_pu;
            ana_r <= next_ana;
            alt_r <= next_alt;
            mon_r <= next_mon;
            samp_r <= next_samp;
        end
    end

    always_comb begin
        cfg_reject_out = reject;
        pad_oe_out = oe_r;
        pad_level_out = lvl_r;
        pad_pullup_out = pu_r;
        analog_sel_out = ana_r;
        alt_sel_out = alt_r;
        monitored_out = mon_r;
        dig_sample_out = samp_r;
    end

    // ***********************************************************
    // checks
    // ***********************************************************
    chk_analog_only_capable: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (analog_sel_out & ~IOLFS_ANALOG_CAPABLE) == 13'h0000) else $error("analog on non-capable line");
    chk_reject_keeps_code: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (cfg_wr_in.wr && !accept && cfg_wr_in.line < 4'hd) |=>
        (cfg_reject_out && fn_code[$past(cfg_wr_in.line)] == $past(fn_code[cfg_wr_in.line])))
        else $error("rejected write changed line");
    chk_write_takes_code: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (cfg_wr_in.wr && accept) |=> (fn_code[$past(cfg_wr_in.line)] == $past(cfg_wr_in.code) && !cfg_reject_out))
        else $error("accepted write not stored");
    chk_out_low_level: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (fn_code[0] == IOLFS_FN_DOUT_LOW) |=> (pad_oe_out[0] && !pad_level_out[0]))
        else $error("code 4 not driving low");
    chk_out_high_level: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (fn_code[4] == IOLFS_FN_DOUT_HIGH) |=> (pad_oe_out[4] && pad_level_out[4]))
        else $error("code 5 not driving high");
    chk_sample_zero_nondin: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (dig_sample_out & (pad_oe_out | analog_sel_out | alt_sel_out)) == 13'h0000)
        else $error("non-input line sampled nonzero");
    chk_ext_alt_lines: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (cfg_wr_in.wr && cfg_wr_in.code >= IOLFS_FN_ALT_FIRST && cfg_wr_in.code <= IOLFS_FN_ALT_LAST
        && cfg_wr_in.line < 4'hd && !IOLFS_EXT_ALT_CAPABLE[cfg_wr_in.line]) |=> cfg_reject_out)
        else $error("codes 6-9 taken on plain line");
    chk_sleep_fixed: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (fn_code[8] == IOLFS_FN_RESET && fn_code[9] == IOLFS_FN_RESET && pad_oe_out[9] == 1'b1 || $past(!rstn_in)))
        else $error("sleep lines altered");
    chk_pullup_din_only: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (pad_pullup_out & (pad_oe_out | analog_sel_out | alt_sel_out)) == 13'h0000)
        else $error("pull-up on non-input line");
endmodule : iolfs_top
`default_nettype wire

// ==== iolfs_pkg.sv ====
/*
 * package for the i/o line function select block: function codes, line
 * capability masks, reset values and the configuration write carrier.
 * assumes a single system clock and a synchronous active-low reset.
 */
`default_nettype none
package iolfs_pkg;

    localparam int unsigned IOLFS_NUM_LINES = 13;
    localparam int unsigned IOLFS_CODE_W = 4;

    // ***********************************************************
    // function codes
    // ***********************************************************
    localparam logic [3:0] IOLFS_FN_DIN_UNMON = 4'h0;
    localparam logic [3:0] IOLFS_FN_ALT_BASE = 4'h1;
    localparam logic [3:0] IOLFS_FN_ANALOG = 4'h2;
    localparam logic [3:0] IOLFS_FN_DIN_MON = 4'h3;
    localparam logic [3:0] IOLFS_FN_DOUT_LOW = 4'h4;
    localparam logic [3:0] IOLFS_FN_DOUT_HIGH = 4'h5;
    localparam logic [3:0] IOLFS_FN_ALT_FIRST = 4'h6;
    localparam logic [3:0] IOLFS_FN_ALT_LAST = 4'h9;

    // ***********************************************************
    // line capabilities, one bit per line index 0..12
    // ***********************************************************
    localparam logic [12:0] IOLFS_ANALOG_CAPABLE = 13'h000f;
    // lines 8 and 9 are the fixed sleep request and sleep status lines
    localparam logic [12:0] IOLFS_CONFIGURABLE = 13'h1cff;
    // lines that own further alternate functions (codes 6..9)
    localparam logic [12:0] IOLFS_EXT_ALT_CAPABLE = 13'h1ce0;
    localparam int unsigned IOLFS_SLEEP_REQ_LINE = 8;
    localparam int unsigned IOLFS_SLEEP_STAT_LINE = 9;

    // ***********************************************************
    // reset values
    // ***********************************************************
    localparam logic [3:0] IOLFS_FN_RESET = 4'h0;
    localparam logic [12:0] IOLFS_PULLUP_RESET = 13'h0000;

    typedef struct packed {
        logic wr;
        logic [3:0] line;
        logic [3:0] code;
    } iolfs_cfg_wr_s;

endpackage : iolfs_pkg
`default_nettype wire

// ==== iolfs_code_check.sv ====
/*
 * combinational acceptance check for one function code on one line.
 * assumes capability masks from the package; no state.
 */
`timescale 1ns/1ps
`default_nettype none
module iolfs_code_check
    import iolfs_pkg::*;
(
    input wire logic [3:0] line_in,
    input wire logic [3:0] code_in,
    output logic accept_out
);
    logic cfg_ok;
    logic ana_ok;
    logic alt_ok;

    always_comb begin
        cfg_ok = (line_in < 4'hd) && IOLFS_CONFIGURABLE[line_in];
        ana_ok = (line_in < 4'hd) && IOLFS_ANALOG_CAPABLE[line_in];
        alt_ok = (line_in < 4'hd) && IOLFS_EXT_ALT_CAPABLE[line_in];
        accept_out = 1'b0;
        if (!cfg_ok) begin
            accept_out = 1'b0;
        end else if (code_in == IOLFS_FN_ANALOG) begin
            accept_out = ana_ok;
        end else if (code_in >= IOLFS_FN_ALT_FIRST && code_in <= IOLFS_FN_ALT_LAST) begin
            accept_out = alt_ok;
        end else if (code_in <= IOLFS_FN_DOUT_HIGH) begin
            accept_out = 1'b1;
        end
    end
endmodule : iolfs_code_check
`default_nettype wire

// ==== iolfs_host_model.sv ====
/*
 * host side model for the i/o line function select block: drives
 * configuration writes one clock at a time.
 * assumes the caller sequences writes and idles through step.
 */
`timescale 1ns/1ps
`default_nettype none
module iolfs_host_model
    import iolfs_pkg::*;
(
    input wire logic sys_clk_in,
    output var iolfs_cfg_wr_s cfg_wr_out
);
    // ***********************************************************
    // write driver
    // ***********************************************************
    initial begin
        cfg_wr_out = '0;
    end

    // launched on the edge so the block samples it one edge later
    task automatic step(input iolfs_cfg_wr_s w);
        @(posedge sys_clk_in);
        cfg_wr_out <= w;
    endtask : step
endmodule : iolfs_host_model
`default_nettype wire

// ==== iolfs_top_tb_top.sv ====
/*
 * self-checking bench for iolfs_top: every code on every line index,
 * back-to-back writes, random traffic, a second reset at the end.
 * assumes the host model file is compiled before this one.
 */
`timescale 1ns/1ps
`default_nettype none
module iolfs_top_tb_top
    import iolfs_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [12:0] pu = 13'h0000;
    logic [12:0] pad = 13'h0000;
    logic sleep = 1'b0;
    iolfs_cfg_wr_s cfg_wr;
    logic rej;
    logic [12:0] oe, lvl, pul, ana, alt, mon, smp;
    logic [51:0] fc;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [3:0] exp_code [13];
    iolfs_cfg_wr_s bw [3];
    logic [15:0] rnd = 16'h0043;

    iolfs_host_model host (.sys_clk_in(sys_clk_in), .cfg_wr_out(cfg_wr));
    iolfs_top DUT (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cfg_wr_in(cfg_wr),
        .pullup_enable_setting_in(pu), .pad_level_in(pad), .sleep_active_in(sleep),
        .cfg_reject_out(rej), .pad_oe_out(oe), .pad_level_out(lvl), .pad_pullup_out(pul),
        .analog_sel_out(ana), .alt_sel_out(alt), .monitored_out(mon),
        .dig_sample_out(smp), .fn_code_out(fc));

    // ***********************************************************
    // helpers
    // ***********************************************************
    initial begin
        forever #4 sys_clk_in = ~sys_clk_in;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic accepts(input logic [3:0] l, input logic [3:0] c);
        if (l > 4'hc || !IOLFS_CONFIGURABLE[l] || c > 4'h9) return 1'b0;
        if (c == IOLFS_FN_ANALOG) return IOLFS_ANALOG_CAPABLE[l];
        if (c >= IOLFS_FN_ALT_FIRST) return IOLFS_EXT_ALT_CAPABLE[l];
        return 1'b1;
    endfunction : accepts

    function automatic logic [51:0] exp_fc();
        logic [51:0] v;
        v = '0;
        for (int n = 0; n < 13; n++) v[4*n +: 4] = exp_code[n];
        return v;
    endfunction : exp_fc

    task automatic check(input string name, input logic [51:0] seen, input logic [51:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // decoded outputs settle after the 2-cycle decode and 3-cycle pad path
    task automatic check_all();
        logic [12:0] din, eoe, elv, ean, eal, emo;
        logic [3:0] c;
        repeat (4) @(posedge sys_clk_in);
        #1;
        for (int n = 0; n < 13; n++) begin
            c = exp_code[n];
            din[n] = (n == 8) || (n != 9 && (c == IOLFS_FN_DIN_UNMON || c == IOLFS_FN_DIN_MON));
            eoe[n] = (n == 9) || (c == IOLFS_FN_DOUT_LOW || c == IOLFS_FN_DOUT_HIGH);
            elv[n] = (n == 9) ? sleep : (c == IOLFS_FN_DOUT_HIGH);
            ean[n] = (c == IOLFS_FN_ANALOG);
            eal[n] = (c == IOLFS_FN_ALT_BASE || c >= IOLFS_FN_ALT_FIRST);
            emo[n] = (c == IOLFS_FN_DIN_MON);
        end
        check("pad_oe", 52'(oe), 52'(eoe));
        check("pad_level", 52'(lvl), 52'(elv));
        check("pullup", 52'(pul), 52'(pu & din));
        check("analog", 52'(ana), 52'(ean));
        check("alt", 52'(alt), 52'(eal));
        check("monitored", 52'(mon), 52'(emo));
        check("sample", 52'(smp), 52'(pad & din));
        check("fn_code", fc, exp_fc());
    endtask : check_all

    // n writes on consecutive edges; reject and code looked at one cycle on
    task automatic burst(input int n);
        for (int i = 0; i <= n; i++) begin
            host.step(i < n ? bw[i] : iolfs_cfg_wr_s'('0));
            if (i == 0) begin
                rnd = lfsr(rnd);
                pad <= rnd[12:0];
                rnd = lfsr(rnd);
                pu <= rnd[12:0];
                sleep <= rnd[15];
            end else begin
                #1;
                if (accepts(bw[i-1].line, bw[i-1].code)) exp_code[bw[i-1].line] = bw[i-1].code;
                check("reject", 52'(rej), 52'(!accepts(bw[i-1].line, bw[i-1].code)));
                check("fn_code_now", fc, exp_fc());
            end
        end
    endtask : burst

    // ***********************************************************
    // main sequence
    // ***********************************************************
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        for (int n = 0; n < 13; n++) exp_code[n] = 4'h0;
        repeat (5) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        check_all();
        for (int l = 0; l < 16; l++) begin
            for (int c = 0; c < 16; c++) begin
                bw[0] = '{1'b1, 4'(l), 4'(c)};
                burst(1);
                check_all();
            end
        end
        bw[0] = '{1'b1, 4'h0, 4'h5};
        bw[1] = '{1'b1, 4'h4, 4'h2};
        bw[2] = '{1'b1, 4'h0, 4'h3};
        burst(3);
        check_all();
        for (int k = 0; k < 150; k++) begin
            rnd = lfsr(rnd);
            bw[0] = '{1'b1, rnd[3:0], rnd[7:4]};
            bw[1] = '{1'b1, rnd[11:8], rnd[15:12]};
            burst(2);
            check_all();
        end
        // a second reset must bring every configurable line back to plain input
        @(posedge sys_clk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        for (int n = 0; n < 13; n++) exp_code[n] = 4'h0;
        check_all();
        report_and_stop();
    end
endmodule : iolfs_top_tb_top
`default_nettype wire
